// [rtl/fault_and_debug_status.sv]
// Purpose: Sticky fault and debug cause registers with AXI4-Lite access
// Assumes: Event inputs are synchronous one-cycle pulses or levels
// Notes: Status bits are write-one-to-clear; a new event beats a clear
`timescale 1ns/100ps

module fault_and_debug_status (
	input wire logic ref_clk_i, // 50 MHz core clock
	input wire logic resetn_i, // Synchronous reset, active low
	input wire fault_debug_pkg::fault_evt_t fault_i, // Fault events
	input wire fault_debug_pkg::debug_evt_t debug_i, // Debug events
	input wire logic halting_debug_en_i, // Halting debug enabled
	input wire logic awvalid_i, // Write address valid
	output logic awready_o, // Write address ready
	input wire logic [11:0] awaddr_i, // Write byte address
	input wire logic wvalid_i, // Write data valid
	output logic wready_o, // Write data ready
	input wire logic [31:0] wdata_i, // Write data
	input wire logic [3:0] wstrb_i, // Write byte strobes
	output logic bvalid_o, // Write response valid
	input wire logic bready_i, // Write response ready
	output logic [1:0] bresp_o, // Write response code
	input wire logic arvalid_i, // Read address valid
	output logic arready_o, // Read address ready
	input wire logic [11:0] araddr_i, // Read byte address
	output logic rvalid_o, // Read data valid
	input wire logic rready_i, // Read data ready
	output logic [31:0] rdata_o, // Read data
	output logic [1:0] rresp_o, // Read response code
	output logic irq_o // Level interrupt
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic hit(input logic [11:0] a,
		input logic [11:0] ofs);
		hit = (a[11:2] == ofs[11:2]);
	endfunction : hit

	function automatic logic [31:0] sticky(input logic [31:0] cur,
		input logic [31:0] set, input logic [31:0] clr,
		input logic [31:0] impl);
		// Set is applied after clear so a same-cycle event survives
		sticky = ((cur & ~clr) | set) & impl;
	endfunction : sticky

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic aw_got_ff, w_got_ff, awready_ff, wready_ff, bvalid_ff;
	logic arready_ff, rvalid_ff, irq_ff;
	logic [1:0] bresp_ff, rresp_ff;
	logic [11:0] awaddr_ff;
	logic [31:0] wdata_ff, rdata_ff;
	logic [3:0] wstrb_ff;
	logic [31:0] cf_ff, hf_ff, de_ff;
	logic [3:0] is_ff, im_ff;

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	wire aw_hs = awvalid_i & awready_ff;
	wire w_hs = wvalid_i & wready_ff;
	wire b_hs = bvalid_ff & bready_i;
	wire wr_do = aw_got_ff & w_got_ff & ~bvalid_ff;
	wire nxt_aw_got = (aw_got_ff | aw_hs) & ~wr_do;
	wire nxt_w_got = (w_got_ff | w_hs) & ~wr_do;
	wire nxt_bvalid = wr_do | (bvalid_ff & ~b_hs);
	wire nxt_awready = ~nxt_aw_got & ~nxt_bvalid;
	wire nxt_wready = ~nxt_w_got & ~nxt_bvalid;

	wire wr_cf = wr_do & hit(awaddr_ff, fault_debug_pkg::OFS_CFG_FAULT);
	wire wr_hf = wr_do & hit(awaddr_ff, fault_debug_pkg::OFS_HARD_FAULT);
	wire wr_de = wr_do & hit(awaddr_ff, fault_debug_pkg::OFS_DEBUG);
	wire wr_is = wr_do & hit(awaddr_ff, fault_debug_pkg::OFS_IRQ_STAT);
	wire wr_im = wr_do & hit(awaddr_ff, fault_debug_pkg::OFS_IRQ_MASK);
	wire wr_mapped = wr_cf | wr_hf | wr_de | wr_is | wr_im;

	wire [31:0] strb_bits = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
		{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
	wire [31:0] wbits = wdata_ff & strb_bits;
	wire [31:0] clr_cf = wr_cf ? wbits : 32'h0000_0000;
	wire [31:0] clr_hf = wr_hf ? wbits : 32'h0000_0000;
	wire [31:0] clr_de = wr_de ? wbits : 32'h0000_0000;
	wire [3:0] clr_is = wr_is ? wbits[3:0] : 4'h0;

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			bvalid_ff <= 1'b0;
			bresp_ff <= fault_debug_pkg::RESP_OKAY;
			awaddr_ff <= 12'h000;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
		end else begin
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			awready_ff <= nxt_awready;
			wready_ff <= nxt_wready;
			bvalid_ff <= nxt_bvalid;
			if (aw_hs) begin
				awaddr_ff <= awaddr_i;
			end
			if (w_hs) begin
				wdata_ff <= wdata_i;
				wstrb_ff <= wstrb_i;
			end
			if (wr_do) begin
				bresp_ff <= wr_mapped ? fault_debug_pkg::RESP_OKAY :
					fault_debug_pkg::RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// Event capture
	// ----------------------------------------------------------------
	wire fetch_hit = fault_i.fetch_violation & fault_i.fetch_issued;
	// Bit 0 is only reachable through the issued-fetch path
	wire [31:0] set_cf = (fault_i.other_cause
		& fault_debug_pkg::CF_IMPL & ~32'h0000_0001)
		| {31'h0000_0000, fetch_hit};

	wire dbg_any = debug_i.external_debug_request | debug_i.vector_catch
		| debug_i.watchpoint | debug_i.breakpoint
		| debug_i.halt_step_request | debug_i.monitor_step;
	// With halting debug on, the debugger owns the event; no hard fault note
	wire dbg_evt_hf = dbg_any & ~halting_debug_en_i;

	wire [31:0] set_hf = {dbg_evt_hf, fault_i.escalated, 28'h000_0000,
		fault_i.vector_read_error, 1'b0};

	wire [31:0] set_de = {27'h000_0000,
		debug_i.external_debug_request,
		debug_i.vector_catch,
		debug_i.watchpoint,
		debug_i.breakpoint,
		debug_i.halt_step_request | debug_i.monitor_step};

	wire [31:0] nxt_cf = sticky(cf_ff, set_cf, clr_cf,
		fault_debug_pkg::CF_IMPL);
	wire [31:0] nxt_hf = sticky(hf_ff, set_hf, clr_hf,
		fault_debug_pkg::HF_IMPL);
	// Cause bits land on the same edge as the hard fault debug flag
	wire [31:0] nxt_de = sticky(de_ff, set_de, clr_de,
		fault_debug_pkg::DE_IMPL);

	// ----------------------------------------------------------------
	// Interrupt status and mask
	// ----------------------------------------------------------------
	wire [3:0] set_is = {dbg_any, fault_i.vector_read_error,
		fault_i.escalated, |set_cf};
	wire [3:0] nxt_is = (is_ff & ~clr_is) | set_is;
	wire [3:0] nxt_im = (wr_im && wstrb_ff[0]) ? wdata_ff[3:0] : im_ff;
	wire nxt_irq = |(nxt_is & nxt_im);

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			cf_ff <= fault_debug_pkg::CF_RST;
			hf_ff <= fault_debug_pkg::HF_RST;
			de_ff <= fault_debug_pkg::DE_RST;
			is_ff <= fault_debug_pkg::IRQ_RST;
			im_ff <= fault_debug_pkg::IRQ_RST;
			irq_ff <= 1'b0;
		end else begin
			cf_ff <= nxt_cf;
			hf_ff <= nxt_hf;
			de_ff <= nxt_de;
			is_ff <= nxt_is;
			im_ff <= nxt_im;
			irq_ff <= nxt_irq;
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	wire ar_hs = arvalid_i & arready_ff;
	wire r_hs = rvalid_ff & rready_i;
	wire nxt_rvalid = ar_hs | (rvalid_ff & ~r_hs);
	wire rd_cf = hit(araddr_i, fault_debug_pkg::OFS_CFG_FAULT);
	wire rd_hf = hit(araddr_i, fault_debug_pkg::OFS_HARD_FAULT);
	wire rd_de = hit(araddr_i, fault_debug_pkg::OFS_DEBUG);
	wire rd_is = hit(araddr_i, fault_debug_pkg::OFS_IRQ_STAT);
	wire rd_im = hit(araddr_i, fault_debug_pkg::OFS_IRQ_MASK);
	wire rd_mapped = rd_cf | rd_hf | rd_de | rd_is | rd_im;
	// Unmapped words read zero and answer with an error
	wire [31:0] rd_word = ({32{rd_cf}} & cf_ff)
		| ({32{rd_hf}} & hf_ff) | ({32{rd_de}} & de_ff)
		| ({32{rd_is}} & {28'h000_0000, is_ff})
		| ({32{rd_im}} & {28'h000_0000, im_ff});

	always_ff @(posedge ref_clk_i) begin
		if (!resetn_i) begin
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= fault_debug_pkg::RESP_OKAY;
		end else begin
			arready_ff <= ~nxt_rvalid;
			rvalid_ff <= nxt_rvalid;
			if (ar_hs) begin
				rdata_ff <= rd_word;
				rresp_ff <= rd_mapped ? fault_debug_pkg::RESP_OKAY :
					fault_debug_pkg::RESP_SLVERR;
			end
		end
	end

	assign awready_o = awready_ff;
	assign wready_o = wready_ff;
	assign bvalid_o = bvalid_ff;
	assign bresp_o = bresp_ff;
	assign arready_o = arready_ff;
	assign rvalid_o = rvalid_ff;
	assign rdata_o = rdata_ff;
	assign rresp_o = rresp_ff;
	assign irq_o = irq_ff;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	property p_fetch_issued;
		$rose(cf_ff[fault_debug_pkg::CF_FETCH_VIOL])
			|-> $past(fault_i.fetch_violation && fault_i.fetch_issued);
	endproperty
	a_fetch_issued: assert property (p_fetch_issued)
		else $error("fetch violation flag set without issued fetch");

	property p_usage_field;
		fault_i.other_cause[fault_debug_pkg::CF_USAGE_LSB]
			|=> cf_ff[fault_debug_pkg::CF_USAGE_LSB];
	endproperty
	a_usage_field: assert property (p_usage_field)
		else $error("usage fault cause not recorded");

	property p_bus_field;
		fault_i.other_cause[fault_debug_pkg::CF_BUS_LSB]
			|=> cf_ff[fault_debug_pkg::CF_BUS_LSB];
	endproperty
	a_bus_field: assert property (p_bus_field)
		else $error("bus fault cause not recorded");

	property p_mem_field;
		fault_i.other_cause[fault_debug_pkg::CF_MEM_MSB]
			|=> cf_ff[fault_debug_pkg::CF_MEM_MSB];
	endproperty
	a_mem_field: assert property (p_mem_field)
		else $error("memory protection cause not recorded");

	property p_dbg_hf;
		$rose(hf_ff[fault_debug_pkg::HF_DEBUG_EVT])
			|-> $past(dbg_any && !halting_debug_en_i);
	endproperty
	a_dbg_hf: assert property (p_dbg_hf)
		else $error("debug event flag set with halting debug on");

	property p_dbg_cause;
		$rose(hf_ff[fault_debug_pkg::HF_DEBUG_EVT])
			|-> ($past(de_ff) != de_ff) || (de_ff != 32'h0000_0000);
	endproperty
	a_dbg_cause: assert property (p_dbg_cause)
		else $error("debug cause not updated with debug event flag");

	property p_forced;
		fault_i.escalated |=> hf_ff[fault_debug_pkg::HF_FORCED];
	endproperty
	a_forced: assert property (p_forced)
		else $error("escalation not recorded");

	property p_vect;
		fault_i.vector_read_error ##1 !wr_hf
			|-> hf_ff[fault_debug_pkg::HF_VECT_READ] ##1
			hf_ff[fault_debug_pkg::HF_VECT_READ];
	endproperty
	a_vect: assert property (p_vect)
		else $error("vector read error not held");

	property p_ext;
		debug_i.external_debug_request
			|=> de_ff[fault_debug_pkg::DE_EXTERNAL];
	endproperty
	a_ext: assert property (p_ext)
		else $error("external debug request not recorded");

	property p_vector_catch_flag;
		debug_i.vector_catch |=> de_ff[fault_debug_pkg::DE_VECTOR_CATCH_FLAG];
	endproperty
	a_vector_catch_flag: assert property (p_vector_catch_flag)
		else $error("vector catch not recorded");

	property p_watch;
		debug_i.watchpoint |=> de_ff[fault_debug_pkg::DE_WATCH];
	endproperty
	a_watch: assert property (p_watch)
		else $error("watchpoint event not recorded");

	property p_breakpoint_event_flag;
		debug_i.breakpoint |=> de_ff[fault_debug_pkg::DE_BREAKPOINT_EVENT_FLAG];
	endproperty
	a_breakpoint_event_flag: assert property (p_breakpoint_event_flag)
		else $error("breakpoint event not recorded");

	property p_halted;
		debug_i.halt_step_request || debug_i.monitor_step
			|=> de_ff[fault_debug_pkg::DE_HALTED];
	endproperty
	a_halted: assert property (p_halted)
		else $error("halt or step request not recorded");

	property p_hold;
		$fell(de_ff[fault_debug_pkg::DE_HALTED]) |-> $past(wr_de);
	endproperty
	a_hold: assert property (p_hold)
		else $error("debug cause bit dropped without a write");

	property p_reserved;
		((cf_ff & ~fault_debug_pkg::CF_IMPL) == 32'h0000_0000)
			&& ((hf_ff & ~fault_debug_pkg::HF_IMPL) == 32'h0000_0000)
			&& ((de_ff & ~fault_debug_pkg::DE_IMPL) == 32'h0000_0000);
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved status bit set");

	property p_irq;
		(|(is_ff & im_ff)) == irq_ff;
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt output disagrees with status and mask");

endmodule : fault_and_debug_status

// [rtl/fault_debug_pkg.sv]
// Purpose: Constants and carriers for the fault and debug status block
// Assumes: 32-bit AXI4-Lite register access, 4 KiB register window
// Notes: Functional notes below list the behaviour the block keeps
//
// Functional notes
// - Fetch violation bit 0 sets only when the faulting fetch is issued.
// - Usage fault status occupies bits 31:16 of the configurable word.
// - Bus fault status occupies bits 15:8 of the configurable word.
// - Memory protection fault status occupies bits 7:0 of that word.
// - Hard fault bit 31 sets on debug event with halting debug off.
// - Debug cause register is updated whenever hard fault bit 31 sets.
// - Hard fault bit 30 sets when a configurable fault is escalated.
// - Hard fault bit 1 sets on vector table read error.
// - Debug cause bit 4 sets on external debug request.
// - Debug cause bit 3 sets on vector catch.
// - Debug cause bit 2 sets on any watchpoint unit debug event.
// - Debug cause bit 1 sets on breakpoint instruction or comparator match.
// - Debug cause bit 0 sets on halt/step request or monitor step.

package fault_debug_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_CFG_FAULT = 12'hD28;
	localparam logic [11:0] OFS_HARD_FAULT = 12'hD2C;
	localparam logic [11:0] OFS_DEBUG = 12'hD30;
	localparam logic [11:0] OFS_IRQ_STAT = 12'hD40;
	localparam logic [11:0] OFS_IRQ_MASK = 12'hD44;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CF_FETCH_VIOL = 0;
	localparam int CF_USAGE_LSB = 16;
	localparam int CF_BUS_MSB = 15;
	localparam int CF_BUS_LSB = 8;
	localparam int CF_MEM_MSB = 7;
	localparam int HF_DEBUG_EVT = 31;
	localparam int HF_FORCED = 30;
	localparam int HF_VECT_READ = 1;
	localparam int DE_EXTERNAL = 4;
	localparam int DE_VECTOR_CATCH_FLAG = 3;
	localparam int DE_WATCH = 2;
	localparam int DE_BREAKPOINT_EVENT_FLAG = 1;
	localparam int DE_HALTED = 0;
	localparam int IRQ_W = 4;
	localparam int IRQ_CFG = 0;
	localparam int IRQ_FORCED = 1;
	localparam int IRQ_VECT = 2;
	localparam int IRQ_DEBUG = 3;

	// ----------------------------------------------------------------
	// Implemented bits and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] CF_IMPL = 32'h010F_BFBB;
	localparam logic [31:0] HF_IMPL = 32'hC000_0002;
	localparam logic [31:0] DE_IMPL = 32'h0000_001F;
	localparam logic [31:0] CF_RST = 32'h0000_0000;
	localparam logic [31:0] HF_RST = 32'h0000_0000;
	localparam logic [31:0] DE_RST = 32'h0000_0000;
	localparam logic [3:0] IRQ_RST = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Event carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic fetch_violation;
		logic fetch_issued;
		logic escalated;
		logic vector_read_error;
		logic [31:0] other_cause;
	} fault_evt_t;

	typedef struct packed {
		logic external_debug_request;
		logic vector_catch;
		logic watchpoint;
		logic breakpoint;
		logic halt_step_request;
		logic monitor_step;
	} debug_evt_t;

endpackage : fault_debug_pkg

// [sim/core_event_model.sv]
// Purpose: Core-side source of fault and debug events for the status block
// Assumes: Each event is a one-cycle pulse launched just after a clock edge
// Notes: Lines drop to zero after the pulse so no flag is set twice
`timescale 1ns/100ps

module core_event_model (
	input wire logic ref_clk_i, // Core clock
	output fault_debug_pkg::fault_evt_t fault_o, // Fault events
	output fault_debug_pkg::debug_evt_t debug_o // Debug events
);
	initial begin
		fault_o = '0;
		debug_o = '0;
	end

	// ----------------------------------------------------------------
	// Event pulse
	// ----------------------------------------------------------------
	// Trailing edges leave time for the status update to settle
	task automatic fire(input fault_debug_pkg::fault_evt_t f,
		input fault_debug_pkg::debug_evt_t d);
		@(posedge ref_clk_i);
		fault_o <= f;
		debug_o <= d;
		@(posedge ref_clk_i);
		fault_o <= '0;
		debug_o <= '0;
		repeat (2) @(posedge ref_clk_i);
	endtask : fire
endmodule : core_event_model

// [sim/test_fault_and_debug_status.sv]
// Purpose: Self-checking bench for the fault and debug status block
// Assumes: Registers reached over AXI4-Lite, one access at a time
// Notes: Every scenario except t_irq clears what it set before it returns; t_irq leaves the interrupt mask at 8
`timescale 1ns/100ps

module test_fault_and_debug_status;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	logic hdbg = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	fault_debug_pkg::fault_evt_t fault;
	fault_debug_pkg::debug_evt_t debug;
	int errors = 0;
	int checks = 0;

	always #10 clk = ~clk;

	core_event_model i_core_event_model (.ref_clk_i(clk),
		.fault_o(fault), .debug_o(debug));

	fault_and_debug_status i_fault_and_debug_status (.ref_clk_i(clk),
		.resetn_i(resetn), .fault_i(fault), .debug_i(debug),
		.halting_debug_en_i(hdbg), .awvalid_i(awvalid),
		.awready_o(awready), .awaddr_i(awaddr), .wvalid_i(wvalid),
		.wready_o(wready), .wdata_i(wdata), .wstrb_i(wstrb),
		.bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp),
		.arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr),
		.rvalid_o(rvalid), .rready_i(rready), .rdata_o(rdata),
		.rresp_o(rresp), .irq_o(irq));

	// ----------------------------------------------------------------
	// Verdict and comparisons
	// ----------------------------------------------------------------
	task test_done;
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : test_done

	task chk_word(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk_word

	task chk_bit(input logic g, input logic e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk_bit

	task chk_resp(input logic [1:0] g, input logic [1:0] e);
		checks++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask : chk_resp

	// ----------------------------------------------------------------
	// Bus cycles
	// ----------------------------------------------------------------
	// Leading edge keeps back-to-back calls from driving twice at once
	task automatic wr_x(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] e);
		bit done;
		done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) begin
				done = 1'b1;
				bready <= 1'b0;
				chk_resp(bresp, e);
			end
		end
	endtask : wr_x

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		wr_x(a, d, 4'hF, fault_debug_pkg::RESP_OKAY);
	endtask : wr

	task automatic rd(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		bit done;
		done = 1'b0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) begin
				done = 1'b1;
				d = rdata;
				r = rresp;
				rready <= 1'b0;
			end
		end
	endtask : rd

	task automatic expect_reg(input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk_resp(r, fault_debug_pkg::RESP_OKAY);
		chk_word(d, e);
	endtask : expect_reg

	task clr_all;
		wr(fault_debug_pkg::OFS_CFG_FAULT, 32'hFFFF_FFFF);
		wr(12'hD2C, 32'hFFFF_FFFF);
		wr(12'hD30, 32'hFFFF_FFFF);
		wr(fault_debug_pkg::OFS_IRQ_STAT, 32'hFFFF_FFFF);
	endtask : clr_all

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		expect_reg(12'hD2C, 32'h0000_0000);
		expect_reg(12'hD30, 32'h0000_0000);
		expect_reg(fault_debug_pkg::OFS_CFG_FAULT, 32'h0000_0000);
		rd(12'h000, d, r);
		chk_resp(r, fault_debug_pkg::RESP_SLVERR);
		chk_word(d, 32'h0000_0000);
		wr_x(12'h000, 32'hFFFF_FFFF, 4'hF, fault_debug_pkg::RESP_SLVERR);
		chk_bit(irq, 1'b0);
	endtask : t_reset

	// Reset in mid-run must drop every flag, the mask and the interrupt
	task t_rst_mid;
		wr(fault_debug_pkg::OFS_IRQ_MASK, 32'h0000_0002);
		i_core_event_model.fire({4'h2, 32'h0000_0000}, '0);
		chk_bit(irq, 1'b1);
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset;
		expect_reg(fault_debug_pkg::OFS_IRQ_MASK, 32'h0000_0000);
	endtask : t_rst_mid

	task automatic t_cfg;
		logic [31:0] sub [3] = '{32'h0001_0000, 32'h0000_0100, 32'h0000_0002};
		for (int i = 0; i < 3; i++) begin
			i_core_event_model.fire({4'h0, sub[i]}, '0);
			expect_reg(12'hD28, sub[i]);
			clr_all;
		end
		i_core_event_model.fire({4'h0, 32'hFFFF_FFFF}, '0);
		expect_reg(fault_debug_pkg::OFS_CFG_FAULT,
			fault_debug_pkg::CF_IMPL & 32'hFFFF_FFFE);
		clr_all;
		expect_reg(fault_debug_pkg::OFS_CFG_FAULT, 32'h0000_0000);
		i_core_event_model.fire({4'h8, 32'h0000_0000}, '0);
		expect_reg(fault_debug_pkg::OFS_CFG_FAULT, 32'h0000_0000);
		i_core_event_model.fire({4'hC, 32'h0000_0000}, '0);
		expect_reg(fault_debug_pkg::OFS_CFG_FAULT, 32'h0000_0001);
		clr_all;
	endtask : t_cfg

	task t_hard;
		i_core_event_model.fire({4'h2, 32'h0000_0000}, '0);
		expect_reg(12'hD2C, 32'h4000_0000);
		i_core_event_model.fire({4'h1, 32'h0000_0000}, '0);
		expect_reg(12'hD2C, 32'h4000_0002);
		wr_x(12'hD2C, 32'hFFFF_FFFF, 4'h7, fault_debug_pkg::RESP_OKAY);
		expect_reg(12'hD2C, 32'h4000_0000);
		clr_all;
		expect_reg(12'hD2C, 32'h0000_0000);
	endtask : t_hard

	task automatic t_debug;
		logic [31:0] de;
		for (int h = 0; h < 2; h++) begin
			hdbg <= h[0];
			for (int i = 0; i < 6; i++) begin
				de = 32'h1 << ((i < 5) ? 4 - i : 0);
				i_core_event_model.fire('0, 6'h20 >> i);
				expect_reg(12'hD30, de);
				expect_reg(12'hD2C, h ? 32'h0 : 32'h8000_0000);
				clr_all;
			end
		end
		hdbg <= 1'b0;
	endtask : t_debug

	task t_irq;
		wr(fault_debug_pkg::OFS_IRQ_MASK, 32'h0000_0008);
		wr_x(12'hD44, 32'h0000_000F, 4'hE, fault_debug_pkg::RESP_OKAY);
		expect_reg(12'hD44, 32'h0000_0008);
		i_core_event_model.fire('0, 6'h04);
		chk_bit(irq, 1'b1);
		wr(fault_debug_pkg::OFS_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge clk);
		chk_bit(irq, 1'b0);
		wr(fault_debug_pkg::OFS_IRQ_MASK, 32'h0000_0008);
		repeat (2) @(posedge clk);
		chk_bit(irq, 1'b1);
		clr_all;
		repeat (2) @(posedge clk);
		chk_bit(irq, 1'b0);
	endtask : t_irq

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset;
		t_cfg;
		t_hard;
		t_debug;
		t_irq;
		t_rst_mid;
		test_done;
	end

	// Whole run needs about six hundred cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		test_done;
	end
endmodule : test_fault_and_debug_status
